// file: rtl/tppwm_dead_time.sv
// dead-time inserter for one phase leg
`timescale 1ns/1ps
`default_nettype none
`include "tppwm_map.svh"
module tppwm_dead_time #(
  parameter int DEAD_CYC = `TPPWM_DEAD_CYC
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic pwm_in, // raw pwm from compare
  output logic top_out, // delayed top drive
  output logic bottom_out // delayed complementary drive
);
  localparam int CW = $clog2(DEAD_CYC + 1);
  logic [CW-1:0] cnt_reg;
  logic last_reg;
  logic top_reg;
  logic bottom_reg;

  // count restarts on every raw edge, so a short pulse never turns either side on
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      last_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      last_reg <= pwm_in;
      if (pwm_in != last_reg) begin
        cnt_reg <= '0;
      end else if (cnt_reg != CW'(DEAD_CYC)) begin
        cnt_reg <= cnt_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      top_reg <= 1'b0;
      bottom_reg <= 1'b0;
    end else if (pwm_in != last_reg) begin
      top_reg <= 1'b0;
      bottom_reg <= 1'b0;
    end else if (cnt_reg == CW'(DEAD_CYC - 1)) begin
      top_reg <= pwm_in;
      bottom_reg <= ~pwm_in;
    end
  end

  assign top_out = top_reg;
  assign bottom_out = bottom_reg;
endmodule // tppwm_dead_time
`default_nettype wire

// file: rtl/tppwm_map.svh
// constants for the three-phase pwm generator with adc trigger
`ifndef TPPWM_MAP_SVH
`define TPPWM_MAP_SVH
`define TPPWM_CLK_HZ 40000000
`define TPPWM_CARRIER_HZ 20000
`define TPPWM_HALF_PERIOD (`TPPWM_CLK_HZ / (2 * `TPPWM_CARRIER_HZ))
`define TPPWM_DEAD_NS 4000
`define TPPWM_DEAD_CYC ((`TPPWM_DEAD_NS * (`TPPWM_CLK_HZ / 1000000) + 999) / 1000)
`define TPPWM_TRIG_NS 1000
`define TPPWM_TRIG_CYC ((`TPPWM_TRIG_NS * (`TPPWM_CLK_HZ / 1000000) + 999) / 1000)
`define TPPWM_CONV_NS 2000
`define TPPWM_CONV_CYC ((`TPPWM_CONV_NS * (`TPPWM_CLK_HZ / 1000000) + 999) / 1000)
`define TPPWM_CULL 1
`define TPPWM_IRQ_LEVEL 3'h4
`define TPPWM_SIN_90 9'h05A
`define TPPWM_SIN_330 9'h14A
`define TPPWM_SIN_240 9'h0F0
`define TPPWM_DEG_FULL 9'h168
`define TPPWM_DEG_HALF 9'h0B4
`define TPPWM_SIN_ONE 16'h4000
`define TPPWM_SIN_FRAC 14
`endif

// file: rtl/tppwm_pkg.sv
// types for the three-phase pwm generator
`default_nettype none
package tppwm_pkg;
  typedef enum logic [1:0] {
    TPPWM_MODE_DIRECT,
    TPPWM_MODE_COORD,
    TPPWM_MODE_LOCK
  } tppwm_mode_e;
  // d/q voltages (signed, full scale +-32767) and angle in degrees 0..359
  typedef struct packed {
    logic signed [15:0] d_volt;
    logic signed [15:0] q_volt;
    logic [8:0] angle_deg;
  } tppwm_dq_s;
  // top and bottom levels with enables, one bit per phase u,v,w
  typedef struct packed {
    logic [2:0] top;
    logic [2:0] bottom;
    logic [2:0] top_oe;
    logic [2:0] bottom_oe;
  } tppwm_gate_s;
endpackage
`default_nettype wire

// file: rtl/tppwm_top.sv
// three-phase complementary pwm generator with synchronous adc triggers
`timescale 1ns/1ps
`default_nettype none
`include "tppwm_map.svh"
// Notes on behaviour
// - coordinate mode derives u, v, w duties from d, q voltages and angle.
// - lock mode keeps the last duties every carrier period until left.
// - software can force all six phase outputs to high impedance.
// - both adc start triggers come once per carrier period, locked to it.
// - main counter sets carrier period and per-phase compare values.
// - a 4 us dead time is inserted into every phase pwm.
// - carrier is 20 kHz and every carrier period is used.
// - trigger timer runs synchronised to the main counter.
// - adc 0 trigger fires 1 us after the carrier valley.
// - adc 1 trigger fires 1 us after the carrier valley.
// - adc 0 done interrupt, level 4, about 2 us after its trigger.
// - adc 1 done interrupt, level 4, about 2 us after its trigger.
// - outputs high impedance until first started; then hi-z, high or low.
// - logic clock is an 8 MHz input multiplied by five in the real part.
// - direct mode uses three supplied duties with no transformation.
// - w voltage is minus u minus v; angles offset 90, 330, 240 degrees.
module tppwm_top #(
  parameter int HALF_PERIOD = `TPPWM_HALF_PERIOD,
  parameter int DEAD_CYC = `TPPWM_DEAD_CYC,
  parameter int TRIG_CYC = `TPPWM_TRIG_CYC,
  parameter int CONV_CYC = `TPPWM_CONV_CYC
) (
  input wire logic clk, // system clock, 40 MHz
  input wire logic sys_rst, // synchronous reset, high
  input wire logic drv_start, // pulse: start driving the outputs
  input wire logic drv_hiz, // level: force all six outputs to high impedance
  input wire tppwm_pkg::tppwm_mode_e drv_mode, // duty source mode
  input wire logic [15:0] duty_u, // direct duty u, counts of half period
  input wire logic [15:0] duty_v, // direct duty v
  input wire logic [15:0] duty_w, // direct duty w
  input wire tppwm_pkg::tppwm_dq_s dq_in, // coordinate-mode operands
  input wire logic [15:0] sin_val, // sine of sin_angle, q14 signed, from table outside
  output logic [8:0] sin_angle, // angle whose sine is requested
  output tppwm_pkg::tppwm_gate_s gate, // six phase outputs with enables
  output logic carrier_valley_event, // one-clock pulse at counter minimum
  output logic adc0_trigger_event, // one-clock start for adc 0
  output logic adc1_trigger_event, // one-clock start for adc 1
  output logic adc0_done_irq, // one-clock conversion done, adc 0
  output logic adc1_done_irq, // one-clock conversion done, adc 1
  output logic [2:0] adc_irq_level // priority level of the done interrupts
);
  localparam int PW = $clog2(HALF_PERIOD + 1);
  localparam int TW = $clog2(TRIG_CYC + CONV_CYC + 2);

  logic [PW-1:0] cnt_reg;
  logic down_reg;
  logic running_reg;
  logic [PW-1:0] cmp_reg [3];
  logic [PW-1:0] cmp_next [3];
  logic [2:0] raw_reg;
  logic [2:0] dt_top;
  logic [2:0] dt_bot;
  logic valley_reg;
  logic [TW-1:0] tcnt_reg;
  logic tact_reg;
  logic trig_reg;
  logic done_reg;

  // coordinate engine: four sine lookups, the u sum right after the second and the v sum right after the fourth
  logic [2:0] step_reg;
  logic signed [31:0] acc_reg;
  logic signed [31:0] vu_reg;
  logic signed [31:0] vv_reg;
  logic signed [31:0] prod;
  logic [8:0] ang_off;
  logic [9:0] ang_sum;

  // running up/down carrier counter; 20 kHz from the half-period count
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
      down_reg <= 1'b0;
    end else if (down_reg) begin
      if (cnt_reg == PW'(1)) begin
        down_reg <= 1'b0;
      end
      cnt_reg <= cnt_reg - PW'(1);
    end else begin
      if (cnt_reg == PW'(HALF_PERIOD - 1)) begin
        down_reg <= 1'b1;
      end
      cnt_reg <= cnt_reg + PW'(1);
    end
  end

  // valley flag: every valley is used, culling 1/1
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      valley_reg <= 1'b0;
    end else begin
      valley_reg <= down_reg && cnt_reg == PW'(1);
    end
  end

  always_comb begin
    ang_off = 9'h000;
    unique case (step_reg)
      3'h0: ang_off = `TPPWM_SIN_90;
      3'h1: ang_off = 9'h000;
      3'h2: ang_off = `TPPWM_SIN_330;
      3'h3: ang_off = `TPPWM_SIN_240;
      default: ang_off = 9'h000;
    endcase
    ang_sum = {1'b0, dq_in.angle_deg} + {1'b0, ang_off};
    if (ang_sum >= {1'b0, `TPPWM_DEG_FULL}) begin
      ang_sum = ang_sum - {1'b0, `TPPWM_DEG_FULL};
    end
    sin_angle = ang_sum[8:0];
  end

  // kept apart from the angle request so the outside sine path is no loop in one process
  always_comb begin
    prod = (step_reg[0] ? 32'(dq_in.q_volt) : 32'(dq_in.d_volt)) * 32'($signed(sin_val));
  end

  // one lookup per clock; the sine source must answer combinationally
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      step_reg <= 3'h0;
      acc_reg <= '0;
      vu_reg <= '0;
      vv_reg <= '0;
    end else begin
      step_reg <= (step_reg == 3'h3) ? 3'h0 : step_reg + 3'h1;
      if (step_reg[0]) begin
        if (step_reg[1]) begin
          vv_reg <= acc_reg - (prod >>> `TPPWM_SIN_FRAC);
        end else begin
          vu_reg <= acc_reg - (prod >>> `TPPWM_SIN_FRAC);
        end
      end else begin
        acc_reg <= prod >>> `TPPWM_SIN_FRAC;
      end
    end
  end

  // map a signed voltage (+-32767) to a compare count of the half period
  function automatic logic [PW-1:0] volt_to_cmp(input logic signed [31:0] v);
    logic signed [47:0] scaled;
    scaled = (48'(v) + 48'sd32768) * 48'(HALF_PERIOD);
    if (scaled < 0) begin
      return '0;
    end else if (scaled >= (48'sd65536 * 48'(HALF_PERIOD))) begin
      return PW'(HALF_PERIOD);
    end
    return PW'(scaled >>> 16);
  endfunction

  always_comb begin
    cmp_next[0] = cmp_reg[0];
    cmp_next[1] = cmp_reg[1];
    cmp_next[2] = cmp_reg[2];
    unique case (drv_mode)
      tppwm_pkg::TPPWM_MODE_DIRECT: begin
        cmp_next[0] = PW'(duty_u);
        cmp_next[1] = PW'(duty_v);
        cmp_next[2] = PW'(duty_w);
      end
      tppwm_pkg::TPPWM_MODE_COORD: begin
        cmp_next[0] = volt_to_cmp(vu_reg);
        cmp_next[1] = volt_to_cmp(vv_reg);
        cmp_next[2] = volt_to_cmp(-vu_reg - vv_reg);
      end
      tppwm_pkg::TPPWM_MODE_LOCK: begin
        cmp_next[0] = cmp_reg[0];
        cmp_next[1] = cmp_reg[1];
        cmp_next[2] = cmp_reg[2];
      end
      default: begin
        cmp_next[0] = cmp_reg[0];
      end
    endcase
  end

  // compare values load only at the valley so a period never sees a torn duty
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmp_reg[0] <= '0;
      cmp_reg[1] <= '0;
      cmp_reg[2] <= '0;
    end else if (down_reg && cnt_reg == PW'(1)) begin
      cmp_reg <= cmp_next;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      raw_reg <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        raw_reg[i] <= cnt_reg < cmp_reg[i];
      end
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_leg
    tppwm_dead_time #(
      .DEAD_CYC(DEAD_CYC)
    ) u_dead (
      .clk(clk),
      .sys_rst(sys_rst),
      .pwm_in(raw_reg[g]),
      .top_out(dt_top[g]),
      .bottom_out(dt_bot[g])
    );
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      running_reg <= 1'b0;
    end else if (drv_start) begin
      running_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gate <= '0;
    end else begin
      gate.top <= dt_top;
      gate.bottom <= dt_bot;
      gate.top_oe <= {3{running_reg && !drv_hiz}};
      gate.bottom_oe <= {3{running_reg && !drv_hiz}};
    end
  end

  // trigger timer restarts at each valley; both adcs share one compare
  // the event flops add a cycle, so each compare sits one count early (needs TRIG_CYC >= 2)
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tcnt_reg <= '0;
      tact_reg <= 1'b0;
      trig_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      trig_reg <= 1'b0;
      done_reg <= 1'b0;
      if (valley_reg) begin
        tcnt_reg <= TW'(1);
        tact_reg <= 1'b1;
      end else if (tact_reg) begin
        tcnt_reg <= tcnt_reg + TW'(1);
        if (tcnt_reg == TW'(TRIG_CYC - 1)) begin
          trig_reg <= 1'b1;
        end
        if (tcnt_reg == TW'(TRIG_CYC + CONV_CYC - 1)) begin
          done_reg <= 1'b1;
          tact_reg <= 1'b0;
        end
      end
    end
  end

  assign carrier_valley_event = valley_reg;
  assign adc0_trigger_event = trig_reg;
  assign adc1_trigger_event = trig_reg;
  assign adc0_done_irq = done_reg;
  assign adc1_done_irq = done_reg;
  assign adc_irq_level = `TPPWM_IRQ_LEVEL;
endmodule // tppwm_top
`default_nettype wire

// file: testbench/three_phase_pwm_adc_trigger_bench.sv
// self-checking bench for the three-phase pwm generator
`timescale 1ns/1ps
`default_nettype none
module three_phase_pwm_adc_trigger_bench;
  localparam int HP = 50;
  localparam int DT = 4;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic drv_start = 1'b0;
  logic drv_hiz = 1'b0;
  tppwm_pkg::tppwm_mode_e drv_mode = tppwm_pkg::TPPWM_MODE_DIRECT;
  logic [15:0] duty [3] = '{16'h0000, 16'h0000, 16'h0000};
  tppwm_pkg::tppwm_dq_s dq_in = '0;
  logic [15:0] sin_val;
  logic [8:0] sin_angle;
  tppwm_pkg::tppwm_gate_s gate;
  logic valley, trig0, trig1, done0, done1;
  logic [2:0] irq_level, w_top, w_bot;
  integer seed = 32'he59b;
  int fail_count = 0;
  int total_checks = 0;
  int on_top [3], on_bot [3], n_ev;
  real exp_d [3], tol;
  initial begin
    forever #12.5 clk = ~clk;
  end
  tppwm_top #(.HALF_PERIOD(HP), .DEAD_CYC(DT), .TRIG_CYC(2), .CONV_CYC(3)) dut (
    .clk(clk), .sys_rst(sys_rst), .drv_start(drv_start), .drv_hiz(drv_hiz),
    .drv_mode(drv_mode), .duty_u(duty[0]), .duty_v(duty[1]), .duty_w(duty[2]),
    .dq_in(dq_in), .sin_val(sin_val), .sin_angle(sin_angle), .gate(gate),
    .carrier_valley_event(valley), .adc0_trigger_event(trig0), .adc1_trigger_event(trig1),
    .adc0_done_irq(done0), .adc1_done_irq(done1), .adc_irq_level(irq_level));
  tppwm_gate_model model (.sin_angle(sin_angle), .gate(gate), .sin_val(sin_val),
    .wire_top(w_top), .wire_bot(w_bot));
  task automatic close_out();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask
  // on-time per carrier period; turn-on edges lose the dead time
  function automatic real exp_on(input real d, input bit top);
    if (d > HP) return top ? 2.0 * HP : 0.0;
    return top ? 2.0 * d - 1.0 - DT : 2.0 * (HP - d) + 1.0 - DT;
  endfunction
  function automatic real rsin(input int a);
    return $sin(a * 3.141592653589793 / 180.0);
  endfunction
  function automatic void coord_expect(input int dv, input int qv, input int a);
    real u, v;
    u = dv * rsin(a + 90) - qv * rsin(a);
    v = dv * rsin(a + 330) - qv * rsin(a + 240);
    exp_d = '{u, v, -u - v};
    for (int p = 0; p < 3; p++) exp_d[p] = (exp_d[p] + 32768.0) * HP / 65536.0;
  endfunction
  // duties load at a valley, so one whole period is skipped before counting
  task automatic run_check();
    int i;
    on_top = '{0, 0, 0};
    on_bot = '{0, 0, 0};
    n_ev = 0;
    repeat (2) begin
      i = 0;
      @(negedge clk);
      while (valley !== 1'b1 && i < 4 * HP) begin
        @(negedge clk);
        i++;
      end
    end
    repeat (2 * HP) begin
      @(negedge clk);
      for (int p = 0; p < 3; p++) begin
        on_top[p] += w_top[p];
        on_bot[p] += w_bot[p];
      end
      n_ev += valley + trig0 + trig1 + done0 + done1;
    end
    for (int p = 0; p < 3; p++) begin
      check(on_top[p] > exp_on(exp_d[p], 1) - tol && on_top[p] < exp_on(exp_d[p], 1) + tol, "top on-time");
      check(on_bot[p] > exp_on(exp_d[p], 0) - tol && on_bot[p] < exp_on(exp_d[p], 0) + tol, "bottom on-time");
    end
    check(n_ev == 5, "events per period");
  endtask
  initial begin
    int d [3];
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    check(gate.top_oe === 3'h0 && gate.bottom_oe === 3'h0, "driven before start");
    drv_start = 1'b1;
    @(negedge clk);
    drv_start = 1'b0;
    repeat (2) @(negedge clk);
    check(gate.top_oe === 3'h7 && gate.bottom_oe === 3'h7, "not driven after start");
    check(irq_level === 3'h4, "irq level");
    tol = 1.5;
    for (int k = 0; k < 5; k++) begin
      @(negedge clk);
      drv_mode = tppwm_pkg::TPPWM_MODE_DIRECT;
      for (int p = 0; p < 3; p++) begin
        exp_d[p] = (k == 4) ? HP + 5 : 6 + {$random(seed)} % 39;
        duty[p] = 16'($rtoi(exp_d[p]));
      end
      run_check();
    end
    @(negedge clk);
    drv_mode = tppwm_pkg::TPPWM_MODE_LOCK;
    duty = '{16'h0006, 16'h0014, 16'h002C};
    run_check();
    // compare truncation inside the block costs up to one duty step
    tol = 3.5;
    for (int k = 0; k < 4; k++) begin
      d[0] = (k == 0) ? 16000 : $random(seed) % 8000;
      d[1] = (k == 0) ? 0 : $random(seed) % 8000;
      d[2] = (k == 0) ? 0 : {$random(seed)} % 360;
      coord_expect(d[0], d[1], d[2]);
      @(negedge clk);
      drv_mode = tppwm_pkg::TPPWM_MODE_COORD;
      dq_in = '{16'(d[0]), 16'(d[1]), 9'(d[2])};
      run_check();
    end
    drv_hiz = 1'b1;
    repeat (3) @(negedge clk);
    check((gate.top_oe | gate.bottom_oe) === 3'h0 && (w_top | w_bot) === 3'h0, "not released");
    drv_hiz = 1'b0;
    run_check();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end
endmodule // three_phase_pwm_adc_trigger_bench
`default_nettype wire

// file: testbench/tppwm_assertions.sv
// port checks of the pwm generator top
`timescale 1ns/1ps
`default_nettype none
module tppwm_assertions #(
  parameter int HALF_PERIOD = 1000,
  parameter int TRIG_CYC = 40,
  parameter int CONV_CYC = 80
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic drv_start, // start pulse
  input wire logic drv_hiz, // forced release
  input wire tppwm_pkg::tppwm_gate_s gate, // phase outputs
  input wire logic carrier_valley_event, // valley pulse
  input wire logic adc0_trigger_event, // adc 0 start
  input wire logic adc1_trigger_event, // adc 1 start
  input wire logic adc0_done_irq, // adc 0 done
  input wire logic adc1_done_irq, // adc 1 done
  input wire logic [2:0] adc_irq_level // done priority
);
  localparam int PERIOD = 2 * HALF_PERIOD;
  logic [15:0] gap_reg;
  logic seen_reg;
  logic started_reg;
  always_ff @(posedge clk) begin
    gap_reg <= (sys_rst || carrier_valley_event) ? 16'h0001 : gap_reg + 16'h0001;
  end
  // the first valley has no predecessor, so spacing is judged from the second on
  always_ff @(posedge clk) begin
    seen_reg <= !sys_rst && (seen_reg || carrier_valley_event);
  end
  always_ff @(posedge clk) begin
    started_reg <= !sys_rst && (started_reg || drv_start);
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_valley_period: assert property (seen_reg |-> carrier_valley_event == (gap_reg == 16'(PERIOD)))
    else $error("valley spacing wrong");
  a_trig_delay: assert property (carrier_valley_event |-> ##TRIG_CYC adc0_trigger_event)
    else $error("trigger late or missing");
  a_trig_cause: assert property (adc0_trigger_event |-> $past(carrier_valley_event, TRIG_CYC))
    else $error("trigger without valley");
  a_trig_pair: assert property (adc0_trigger_event == adc1_trigger_event)
    else $error("triggers differ");
  a_done_delay: assert property (adc0_trigger_event |-> ##CONV_CYC adc0_done_irq && adc1_done_irq)
    else $error("done late or missing");
  a_done_cause: assert property (adc0_done_irq || adc1_done_irq |-> $past(adc0_trigger_event, CONV_CYC))
    else $error("done without trigger");
  a_irq_level: assert property (adc_irq_level == 3'h4)
    else $error("irq level wrong");
  a_no_overlap: assert property ((gate.top & gate.bottom) == 3'h0)
    else $error("top and bottom both on");
  a_dead_gap: assert property ($fell(gate.top[0]) |-> !gate.bottom[0] [*4])
    else $error("dead time too short");
  a_idle_hiz: assert property (!started_reg |-> (gate.top_oe | gate.bottom_oe) == 3'h0)
    else $error("driven before start");
  a_hiz_force: assert property (drv_hiz [*3] |-> (gate.top_oe | gate.bottom_oe) == 3'h0)
    else $error("forced release ignored");
  a_start_drive: assert property (drv_start && !drv_hiz ##1 !drv_hiz [*2] |-> (gate.top_oe & gate.bottom_oe) == 3'h7)
    else $error("drive not enabled");
  c_done: cover property (adc0_done_irq);
  c_hiz: cover property (drv_hiz [*3]);
  c_edge: cover property ($fell(gate.top[0]));
endmodule // tppwm_assertions
bind tppwm_top tppwm_assertions #(.HALF_PERIOD(HALF_PERIOD), .TRIG_CYC(TRIG_CYC), .CONV_CYC(CONV_CYC)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .drv_start(drv_start), .drv_hiz(drv_hiz), .gate(gate),
  .carrier_valley_event(carrier_valley_event), .adc0_trigger_event(adc0_trigger_event),
  .adc1_trigger_event(adc1_trigger_event), .adc0_done_irq(adc0_done_irq),
  .adc1_done_irq(adc1_done_irq), .adc_irq_level(adc_irq_level));
`default_nettype wire

// file: testbench/tppwm_gate_model.sv
// gate-driver stage and sine table on the far side of the pwm generator
`timescale 1ns/1ps
`default_nettype none
module tppwm_gate_model (
  input wire logic [8:0] sin_angle, // angle whose sine is asked for
  input wire tppwm_pkg::tppwm_gate_s gate, // drive levels and enables
  output logic [15:0] sin_val, // q14 sine answer
  output logic [2:0] wire_top, // top gate line level
  output logic [2:0] wire_bot // bottom gate line level
);
  real s;
  always_comb begin
    s = $sin(sin_angle * 3.141592653589793 / 180.0) * 16384.0;
    sin_val = 16'($rtoi(s < 0.0 ? s - 0.5 : s + 0.5));
  end
  // driver inputs have pull-downs, so a released line reads low and keeps the switch off
  assign wire_top = gate.top & gate.top_oe;
  assign wire_bot = gate.bottom & gate.bottom_oe;
endmodule // tppwm_gate_model
`default_nettype wire
